// *** core/mode_ctrl_pkg.sv ***
/*
  Constants and carrier types for the operating-mode and reset controller.
  Assumes a single 250 MHz system clock; low-power clock selection is reported
  to an external clock mux, not generated here.
*/
package mode_ctrl_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS      = 4;
  localparam int EXT_RST_MIN_CYC    = 4;      // pin low this long to take effect
  localparam int EXT_RST_RESUME_CYC = 4;      // resume delay outside stop mode
  localparam int RC_CYCLE_NS        = 125;    // internal rc oscillator period, 8 MHz
  localparam int STOP_RESUME_RC_CYC = 128;    // rc cycles after release from stop
  localparam int STOP_RESUME_CYC    = (STOP_RESUME_RC_CYC * RC_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LP_CLK_DIV         = 8;      // rc divider in low-power mode
  localparam int WDOG_PERIOD_DEF    = 65536;
  localparam int RST_PULSE_DEF      = 16;
  localparam int CNT_W              = 20;
  localparam logic [CNT_W-1:0] CNT_ZERO = 20'h00000;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_INIT,
    MODE_RUN,
    MODE_LPM,
    MODE_STOP,
    MODE_RESET
  } op_mode_t;

  // master command strobes, each a one-cycle pulse
  typedef struct packed {
    logic clr_pending;
    logic set_lp;
    logic clr_lp;
    logic stop_req;
    logic cmd_done;
    logic soft_rst;
  } cmd_t;

  typedef struct packed {
    logic measure_en;
    logic respond_en;
    logic clk_low_power;
    logic wdog_run;
    logic bod_en;
  } ctrl_t;

endpackage

// *** core/meter_mode_and_reset_control.sv ***
/*
  Operating-mode and reset controller: initialization, run, low-power
  measurement and stop modes, plus external, power-on, watchdog and software
  resets. Assumes commands come as single-cycle strobes from the command
  decoder on the same clock; the reset pin, slave select and supply-low come
  from pins and are synchronised here. Power-on reset also drives rst_n_in.
*/
// Behaviour
// - four modes; initialization after power-up or reset; others by command only
// - entering initialization sets pending flag and pulls interrupt request low
// - no measurement while in initialization
// - pending clear moves to run, or low-power mode if low-power select set
// - run mode measures, serves master, emits pulses, raises unmasked interrupts
// - low-power mode selects rc clock divided by eight, metering kept
// - setting low-power select sets pending flag and returns to initialization
// - low-power select set at init goes straight to low-power on pending clear
// - clearing low-power select sets pending flag; master reconfigures before resuming
// - stop mode suspends everything and ignores master commands
// - stop request enters stop after the write command's final acknowledge
// - power-on reset leaves stop, defaults registers, enters initialization
// - external reset from stop resumes after 128 rc cycles past release
// - slave select low in stop wakes without reset, keeps settings
// - supply-low and watchdog resets drive reset pin low; external reset does not drive it
// - external reset outside stop resumes after four cycles, low-power cleared
// - supply-low holds power-on reset; release defaults and selects fast clock
// - brownout disabled in stop; both reset kinds look the same to master
// - watchdog expiry pulses reset pin, re-enters initialization; idle in stop
// - software reset defaults like external reset without driving reset pin
module meter_mode_and_reset_control
#(
  parameter int WDOG_PERIOD = mode_ctrl_pkg::WDOG_PERIOD_DEF,
  parameter int RST_PULSE   = mode_ctrl_pkg::RST_PULSE_DEF
)
(
  // clock and reset
  input  wire logic                 clk_sys_in,
  input  wire logic                 rst_n_in,
  // pins
  input  wire logic                 reset_pin_n_in,
  output logic                      reset_pin_n_out,
  output logic                      reset_pin_oe_out,
  input  wire logic                 ssel_n_in,
  input  wire logic                 supply_low_in,
  // master commands and internal activity
  input  mode_ctrl_pkg::cmd_t       cmd_in,
  input  wire logic                 wdog_kick_in,
  // status and control
  output mode_ctrl_pkg::op_mode_t   mode_out,
  output logic                      config_pending_flag_out,
  output logic                      low_power_select_out,
  output logic                      irq_n_out,
  output logic                      regs_default_out,
  output mode_ctrl_pkg::ctrl_t      ctrl_out
);
  import mode_ctrl_pkg::*;

  localparam logic [CNT_W-1:0] WDOG_LAST  = CNT_W'(WDOG_PERIOD - 1);
  localparam logic [CNT_W-1:0] PULSE_LAST = CNT_W'(RST_PULSE - 1);
  localparam logic [CNT_W-1:0] EXT_LAST   = CNT_W'(EXT_RST_MIN_CYC - 1);
  localparam logic [CNT_W-1:0] RES_SHORT  = CNT_W'(EXT_RST_RESUME_CYC);
  localparam logic [CNT_W-1:0] RES_STOP   = CNT_W'(STOP_RESUME_CYC);

  typedef struct packed {
    logic [1:0]       pin_sync;
    logic [1:0]       ssel_sync;
    logic [1:0]       sup_sync;
    op_mode_t         mode;
    logic             pending;
    logic             low_power;
    logic             stop_armed;
    logic             ext_held;
    logic             from_stop;
    logic             drive_pin;
    logic             deflt;
    logic [CNT_W-1:0] low_cnt;
    logic [CNT_W-1:0] resume_cnt;
    logic [CNT_W-1:0] pulse_cnt;
    logic [CNT_W-1:0] wdog_cnt;
  } state_t;

  localparam state_t RESET_STATE = '{
    pin_sync:   2'h3,
    ssel_sync:  2'h3,
    sup_sync:   2'h0,
    mode:       MODE_INIT,
    pending:    1'b1,
    low_power:  1'b0,
    stop_armed: 1'b0,
    ext_held:   1'b0,
    from_stop:  1'b0,
    drive_pin:  1'b0,
    deflt:      1'b1,
    low_cnt:    CNT_ZERO,
    resume_cnt: CNT_ZERO,
    pulse_cnt:  CNT_ZERO,
    wdog_cnt:   CNT_ZERO
  };

  state_t state_r;
  state_t state_nxt;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic pin_low;
    logic ssel_low;
    logic sup_low;
    logic active;
    pin_low   = 1'b0;
    ssel_low  = 1'b0;
    sup_low   = 1'b0;
    active    = 1'b0;
    state_nxt = state_r;
    state_nxt.pin_sync  = {state_r.pin_sync[0], reset_pin_n_in};
    state_nxt.ssel_sync = {state_r.ssel_sync[0], ssel_n_in};
    state_nxt.sup_sync  = {state_r.sup_sync[0], supply_low_in};
    state_nxt.deflt     = 1'b0;
    // our own pin drive reads back low; only count low from outside
    pin_low  = ~state_r.pin_sync[1] & ~state_r.drive_pin;
    ssel_low = ~state_r.ssel_sync[1];
    sup_low  = state_r.sup_sync[1] & (state_r.mode != MODE_STOP);
    active   = (state_r.mode == MODE_INIT) | (state_r.mode == MODE_RUN) | (state_r.mode == MODE_LPM);

    // external reset qualification
    if (pin_low)
    begin
      if (state_r.low_cnt != EXT_LAST)
      begin
        state_nxt.low_cnt = state_r.low_cnt + CNT_W'(1);
      end
    end
    else
    begin
      state_nxt.low_cnt = CNT_ZERO;
    end

    if (sup_low)
    begin
      // held in power-on reset while supply is low, pin driven
      state_nxt = RESET_STATE;
      state_nxt.pin_sync  = {state_r.pin_sync[0], reset_pin_n_in};
      state_nxt.ssel_sync = {state_r.ssel_sync[0], ssel_n_in};
      state_nxt.sup_sync  = {state_r.sup_sync[0], supply_low_in};
      state_nxt.mode      = MODE_RESET;
      state_nxt.drive_pin = 1'b1;
      state_nxt.resume_cnt = RES_SHORT;
    end
    else if (pin_low && state_r.low_cnt == EXT_LAST)
    begin
      // taken: defaults apply and persist while pin held
      state_nxt.mode      = MODE_RESET;
      state_nxt.ext_held  = 1'b1;
      if (state_r.mode != MODE_RESET)
      begin
        state_nxt.from_stop = (state_r.mode == MODE_STOP);
      end
      state_nxt.pending   = 1'b1;
      state_nxt.low_power = 1'b0;
      state_nxt.stop_armed = 1'b0;
      state_nxt.deflt     = 1'b1;
      state_nxt.wdog_cnt  = CNT_ZERO;
    end
    else
    begin
      case (state_r.mode)
        MODE_RESET:
        begin
          if (state_r.ext_held)
          begin
            state_nxt.ext_held   = 1'b0;
            state_nxt.resume_cnt = state_r.from_stop ? RES_STOP : RES_SHORT;
          end
          else if (state_r.pulse_cnt != CNT_ZERO)
          begin
            state_nxt.pulse_cnt = state_r.pulse_cnt - CNT_W'(1);
            if (state_r.pulse_cnt == CNT_W'(1))
            begin
              state_nxt.drive_pin  = 1'b0;
              state_nxt.resume_cnt = RES_SHORT;
            end
          end
          else if (state_r.drive_pin)
          begin
            // power-on reset just released
            state_nxt.drive_pin = 1'b0;
          end
          else if (state_r.resume_cnt > CNT_W'(1))
          begin
            state_nxt.resume_cnt = state_r.resume_cnt - CNT_W'(1);
          end
          else
          begin
            state_nxt.resume_cnt = CNT_ZERO;
            state_nxt.from_stop  = 1'b0;
            state_nxt.mode       = MODE_INIT;
            state_nxt.pending    = 1'b1;
          end
        end
        MODE_INIT, MODE_RUN, MODE_LPM:
        begin
          if (cmd_in.soft_rst)
          begin
            // defaults without pin drive
            state_nxt.mode       = MODE_INIT;
            state_nxt.pending    = 1'b1;
            state_nxt.low_power  = 1'b0;
            state_nxt.stop_armed = 1'b0;
            state_nxt.deflt      = 1'b1;
            state_nxt.wdog_cnt   = CNT_ZERO;
          end
          else if (state_r.wdog_cnt == WDOG_LAST)
          begin
            state_nxt.mode      = MODE_RESET;
            state_nxt.drive_pin = 1'b1;
            state_nxt.pulse_cnt = PULSE_LAST + CNT_W'(1);
            state_nxt.pending   = 1'b1;
            state_nxt.low_power = 1'b0;
            state_nxt.stop_armed = 1'b0;
            state_nxt.deflt     = 1'b1;
            state_nxt.wdog_cnt  = CNT_ZERO;
          end
          else
          begin
            state_nxt.wdog_cnt = wdog_kick_in ? CNT_ZERO : state_r.wdog_cnt + CNT_W'(1);
            if (cmd_in.stop_req)
            begin
              state_nxt.stop_armed = 1'b1;
            end
            if (state_r.stop_armed && cmd_in.cmd_done)
            begin
              state_nxt.mode       = MODE_STOP;
              state_nxt.stop_armed = 1'b0;
              state_nxt.wdog_cnt   = CNT_ZERO;
            end
            else if (cmd_in.set_lp && !state_r.low_power)
            begin
              state_nxt.low_power = 1'b1;
              state_nxt.pending   = 1'b1;
              state_nxt.mode      = MODE_INIT;
            end
            else if (cmd_in.clr_lp && state_r.low_power)
            begin
              state_nxt.low_power = 1'b0;
              state_nxt.pending   = 1'b1;
              state_nxt.mode      = MODE_INIT;
            end
            else if (cmd_in.clr_pending && state_r.mode == MODE_INIT)
            begin
              state_nxt.pending = 1'b0;
              state_nxt.mode    = state_r.low_power ? MODE_LPM : MODE_RUN;
            end
          end
        end
        MODE_STOP:
        begin
          // commands ignored; only slave select or a reset leaves
          if (ssel_low)
          begin
            state_nxt.mode = state_r.pending ? MODE_INIT : (state_r.low_power ? MODE_LPM : MODE_RUN);
          end
        end
        default:
        begin
          state_nxt.mode = MODE_RESET;
        end
      endcase
    end
    if (!active)
    begin
      state_nxt.wdog_cnt = (state_nxt.mode == MODE_STOP || state_nxt.mode == MODE_RESET) ? CNT_ZERO
                           : state_nxt.wdog_cnt;
    end
    state_nxt.wdog_cnt = (state_r.mode == MODE_STOP) ? CNT_ZERO : state_nxt.wdog_cnt;

  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_r <= RESET_STATE;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign mode_out                = state_r.mode;
  assign config_pending_flag_out = state_r.pending;
  assign low_power_select_out    = state_r.low_power;
  assign irq_n_out               = ~(state_r.pending & (state_r.mode == MODE_INIT));
  assign regs_default_out        = state_r.deflt;
  assign reset_pin_n_out         = 1'b0;
  assign reset_pin_oe_out        = state_r.drive_pin;
  assign ctrl_out.measure_en     = (state_r.mode == MODE_RUN) | (state_r.mode == MODE_LPM);
  assign ctrl_out.respond_en     = (state_r.mode != MODE_STOP) & (state_r.mode != MODE_RESET);
  assign ctrl_out.clk_low_power  = state_r.low_power;
  assign ctrl_out.wdog_run       = (state_r.mode != MODE_STOP) & (state_r.mode != MODE_RESET);
  assign ctrl_out.bod_en         = (state_r.mode != MODE_STOP);

endmodule

// *** test/mode_ctrl_sva.sv ***
/*
  Assertion checker for the mode and reset controller, bound to its ports.
  Assumes one clock domain and the asynchronous active-low reset.
*/
module mode_ctrl_sva
#(
  parameter int WDOG_PERIOD = 64,
  parameter int RST_PULSE   = 4
)
(
  // clock and reset
  input wire logic                    clk_sys_in,
  input wire logic                    rst_n_in,
  // pins
  input wire logic                    reset_pin_n_in,
  input wire logic                    reset_pin_n_out,
  input wire logic                    reset_pin_oe_out,
  input wire logic                    ssel_n_in,
  input wire logic                    supply_low_in,
  // commands and status
  input wire mode_ctrl_pkg::cmd_t     cmd_in,
  input wire logic                    wdog_kick_in,
  input wire mode_ctrl_pkg::op_mode_t mode_out,
  input wire logic                    config_pending_flag_out,
  input wire logic                    low_power_select_out,
  input wire logic                    irq_n_out,
  input wire logic                    regs_default_out,
  input wire mode_ctrl_pkg::ctrl_t    ctrl_out
);
  import mode_ctrl_pkg::*;
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);
  localparam int PULSE_HOLD = RST_PULSE - 1;
  // ----------------------------------------
  // sequences and properties
  // ----------------------------------------
  sequence s_stop_cmd;
    mode_out == MODE_RUN && cmd_in == 6'h04 ##1 cmd_in == 6'h02;
  endsequence
  sequence s_quiet_stop;
    (ssel_n_in && reset_pin_n_in)[*8] ##0 mode_out == MODE_STOP;
  endsequence
  init_irq_a: assert property (mode_out == MODE_INIT && config_pending_flag_out && $past(mode_out) == MODE_INIT
    && $past(config_pending_flag_out) |-> !irq_n_out) else $error("irq not low in init");
  no_meas_a: assert property (!(mode_out inside {MODE_RUN, MODE_LPM}) |-> !ctrl_out.measure_en)
    else $error("measuring outside run");
  lpm_clk_a: assert property (mode_out == MODE_LPM |-> ctrl_out.clk_low_power)
    else $error("low-power clock not selected");
  clr_go_a: assert property (mode_out == MODE_INIT && cmd_in == 6'h20
    |=> mode_out == (low_power_select_out ? MODE_LPM : MODE_RUN)) else $error("pending clear did not start");
  lp_set_a: assert property (mode_out == MODE_RUN && cmd_in == 6'h10
    |=> mode_out == MODE_INIT && config_pending_flag_out && low_power_select_out) else $error("set lp wrong");
  lp_clr_a: assert property (mode_out == MODE_LPM && cmd_in == 6'h08
    |=> mode_out == MODE_INIT && config_pending_flag_out && !low_power_select_out) else $error("clr lp wrong");
  stop_enter_a: assert property (s_stop_cmd |=> mode_out == MODE_STOP)
    else $error("stop not entered");
  stop_hold_a: assert property (s_quiet_stop |=> mode_out == MODE_STOP)
    else $error("left stop without wake");
  pin_rst_a: assert property ((!reset_pin_n_in)[*8] |-> mode_out == MODE_RESET
    && config_pending_flag_out && !low_power_select_out) else $error("pin reset not held");
  soft_pin_a: assert property (mode_out inside {MODE_RUN, MODE_LPM} && cmd_in == 6'h01
    |=> !reset_pin_oe_out throughout (##[0:12] mode_out == MODE_INIT)) else $error("soft reset wrong");
  wdog_pulse_a: assert property ($past(mode_out) inside {MODE_INIT, MODE_RUN, MODE_LPM}
    && mode_out == MODE_RESET && reset_pin_oe_out && !$past(supply_low_in, 3)
    |-> ##PULSE_HOLD reset_pin_oe_out ##1 !reset_pin_oe_out) else $error("watchdog pulse length wrong");
endmodule

bind meter_mode_and_reset_control mode_ctrl_sva #(.WDOG_PERIOD(WDOG_PERIOD), .RST_PULSE(RST_PULSE)) sva_i
(
  .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .reset_pin_n_in(reset_pin_n_in),
  .reset_pin_n_out(reset_pin_n_out), .reset_pin_oe_out(reset_pin_oe_out), .ssel_n_in(ssel_n_in),
  .supply_low_in(supply_low_in), .cmd_in(cmd_in), .wdog_kick_in(wdog_kick_in), .mode_out(mode_out),
  .config_pending_flag_out(config_pending_flag_out), .low_power_select_out(low_power_select_out),
  .irq_n_out(irq_n_out), .regs_default_out(regs_default_out), .ctrl_out(ctrl_out)
);

// *** test/master_model.sv ***
/*
  Master-side model: drives the shared reset pin and slave select.
  Assumes a weak pull-up on the reset pin, so a released pin reads high.
*/
module master_model
(
  // clock and device drive
  input  wire logic clk_sys_in,
  input  wire logic pin_oe_in,
  input  wire logic pin_d_in,
  // bench requests
  input  wire logic hold_rst_in,
  input  wire logic wake_in,
  // pins
  output logic      pin_n_out,
  output logic      ssel_n_out
);
  timeunit 1ns;
  timeprecision 100ps;
  int   held = 4;
  logic drv = 1'h0;
  // a reset request is stretched to at least four clock cycles
  always @(posedge clk_sys_in)
  begin
    held <= hold_rst_in ? 0 : (held < 4 ? held + 1 : 4);
    drv  <= hold_rst_in || held < 4;
  end
  assign pin_n_out  = !drv && (pin_oe_in ? pin_d_in : 1'h1);
  assign ssel_n_out = !wake_in;
endmodule

// *** test/tb.sv ***
/*
  Self-checking bench for the mode and reset controller.
  Assumes the master model and the bound checker are compiled first.
*/
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import mode_ctrl_pkg::*;
  logic       clk = 1'h0, rst_n = 1'h0, kick_en = 1'h0, kick = 1'h0;
  logic       supply = 1'h0, hold = 1'h0, wake = 1'h0, dflt_seen = 1'h0, mon_clr = 1'h0;
  logic       oe, dflt, pend, lp, irq_n, pin_do;
  logic [5:0] cmd = 6'h00;
  logic [7:0] oe_cyc = 8'h00;
  wire        pin_n, ssel_n;
  op_mode_t   mode;
  ctrl_t      ctrl;
  int         err_total = 0, n_tests = 0, n;

  initial forever #2 clk = ~clk;
  always @(negedge clk) kick <= kick_en && !kick;
  always @(posedge clk)
  begin
    oe_cyc    <= mon_clr ? 8'h00 : oe_cyc + 8'(oe);
    dflt_seen <= !mon_clr && (dflt_seen | dflt);
  end
  meter_mode_and_reset_control #(.WDOG_PERIOD(64), .RST_PULSE(4)) uut
  (
    .clk_sys_in(clk), .rst_n_in(rst_n), .reset_pin_n_in(pin_n), .reset_pin_n_out(pin_do), .reset_pin_oe_out(oe),
    .ssel_n_in(ssel_n), .supply_low_in(supply), .cmd_in(cmd_t'(cmd)), .wdog_kick_in(kick), .mode_out(mode),
    .config_pending_flag_out(pend), .low_power_select_out(lp), .irq_n_out(irq_n), .regs_default_out(dflt),
    .ctrl_out(ctrl)
  );
  master_model mm
  (
    .clk_sys_in(clk), .pin_oe_in(oe), .pin_d_in(pin_do), .hold_rst_in(hold), .wake_in(wake), .pin_n_out(pin_n),
    .ssel_n_out(ssel_n)
  );
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic stop_test();
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cm(input op_mode_t m);
    chk("mode", 8'(mode), 8'(m));
  endtask
  task automatic wait_mode(input op_mode_t m, input int lim);
    n = 0;
    while (mode !== m && n < lim)
    begin
      @(negedge clk);
      n++;
    end
    cm(m);
    if (mode !== m)
      stop_test();
  endtask
  task automatic send(input logic [5:0] c);
    cmd = c;
    @(negedge clk);
    cmd = 6'h00;
    @(negedge clk);
  endtask
  task automatic go_stop();
    cmd = 6'h04;
    @(negedge clk);
    cmd = 6'h02;
    @(negedge clk);
    cmd = 6'h00;
    @(negedge clk);
  endtask
  // zero the oe cycle count and default-pulse monitor at the next edge
  task automatic clr_mon();
    mon_clr = 1'h1;
    @(negedge clk);
    mon_clr = 1'h0;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_modes();
    cm(MODE_INIT);
    chk("irq_n", irq_n, 1'h0);
    chk("meas", ctrl.measure_en, 1'h0);
    chk("pend", pend, 1'h1);
    send(6'h20);
    cm(MODE_RUN);
    chk("meas", ctrl.measure_en, 1'h1);
    send(6'h10);
    chk("pend", pend, 1'h1);
    send(6'h20);
    cm(MODE_LPM);
    chk("lp clk", ctrl.clk_low_power, 1'h1);
    send(6'h08);
    chk("lp", lp, 1'h0);
    send(6'h10);
    send(6'h20);
    cm(MODE_LPM);
  endtask
  task automatic t_soft();
    clr_mon();
    send(6'h01);
    wait_mode(MODE_INIT, 16);
    chk("lp", lp, 1'h0);
    chk("dflt", dflt_seen, 1'h1);
    chk("oe cycles", oe_cyc, 8'h00);
  endtask
  task automatic t_stop();
    send(6'h20);
    go_stop();
    cm(MODE_STOP);
    send(6'h10);
    chk("lp", lp, 1'h0);
    chk("respond", ctrl.respond_en, 1'h0);
    chk("bod", ctrl.bod_en, 1'h0);
    chk("wdog run", ctrl.wdog_run, 1'h0);
    kick_en = 1'h0;
    repeat (100) @(negedge clk);
    cm(MODE_STOP);
    kick_en = 1'h1;
    wake = 1'h1;
    wait_mode(MODE_RUN, 8);
    wake = 1'h0;
    chk("respond", ctrl.respond_en, 1'h1);
    chk("bod", ctrl.bod_en, 1'h1);
    chk("wdog run", ctrl.wdog_run, 1'h1);
  endtask
  task automatic t_ext();
    clr_mon();
    hold = 1'h1;
    wait_mode(MODE_RESET, 12);
    repeat (20) @(negedge clk);
    cm(MODE_RESET);
    hold = 1'h0;
    wait_mode(MODE_INIT, 16);
    chk("dflt", dflt_seen, 1'h1);
    send(6'h20);
    go_stop();
    hold = 1'h1;
    repeat (10) @(negedge clk);
    hold = 1'h0;
    wait_mode(MODE_INIT, 5000);
    chk("resume", 8'(n >= 4000 && n < 4020), 8'h01);
  endtask
  task automatic t_wdog();
    send(6'h20);
    clr_mon();
    kick_en = 1'h0;
    wait_mode(MODE_RESET, 100);
    chk("pin drive", pin_do, 1'h0);
    chk("pin level", pin_n, 1'h0);
    kick_en = 1'h1;
    wait_mode(MODE_INIT, 20);
    chk("oe cycles", oe_cyc, 8'h04);
    chk("irq_n", irq_n, 1'h0);
  endtask
  task automatic t_power();
    send(6'h10);
    supply = 1'h1;
    wait_mode(MODE_RESET, 8);
    repeat (10) @(negedge clk);
    chk("oe", oe, 1'h1);
    supply = 1'h0;
    wait_mode(MODE_INIT, 16);
    chk("lp", lp, 1'h0);
    send(6'h20);
    go_stop();
    supply = 1'h1;
    repeat (10) @(negedge clk);
    cm(MODE_STOP);
    supply = 1'h0;
    rst_n = 1'h0;
    @(negedge clk);
    rst_n = 1'h1;
    @(negedge clk);
    cm(MODE_INIT);
    chk("pend", pend, 1'h1);
  endtask

  initial
  begin
    repeat (5) @(negedge clk);
    rst_n = 1'h1;
    kick_en = 1'h1;
    @(negedge clk);
    t_modes();
    t_soft();
    t_stop();
    t_ext();
    t_wdog();
    t_power();
    stop_test();
  end
endmodule
